/* File: rtl/rsf_pkg.sv */
package rsf_pkg;
    localparam logic [15:0] A_SEQ_CTRL = 16'h2004;
    localparam logic [15:0] A_BUF_CFG  = 16'h2008;
    localparam logic [15:0] A_SYNC     = 16'h2054;
    localparam logic [15:0] A_POP      = 16'h206C;
    localparam logic [15:0] A_MEM_CTRL = 16'h21D8;
    localparam logic [15:0] A_THR      = 16'h21E0;
    localparam logic [15:0] A_OCC      = 16'h2200;
    localparam logic [15:0] A_FLAGS    = 16'h3000;
    localparam logic [15:0] A_PIN_OE   = 16'h3004;
    localparam logic [15:0] A_PIN_FN   = 16'h3008;
    localparam logic [15:0] A_PIN_EVT  = 16'h300C;
    localparam logic [15:0] SEQ_CTRL_RST = 16'h0002;
    localparam logic [15:0] BUF_CFG_RST  = 16'h1010;
    localparam logic [15:0] MEM_CTRL_RST = 16'h0410;
    localparam int SEQ_EN_BIT  = 0;
    localparam int SEQ_HALT_BIT = 4;
    localparam int BUF_EN_BIT  = 11;
    localparam int SRC_LSB     = 13;
    localparam int MODE_LSB    = 9;
    localparam int MSEL_LSB    = 6;
    localparam int OCC_LSB     = 16;
    localparam int MEM_WORDS   = 1536;
    localparam logic [10:0] CAP_2K = 11'h200;
    localparam logic [10:0] CAP_4K = 11'h400;
    localparam logic [10:0] CAP_6K = 11'h600;
    localparam logic [2:0] MSEL_4K = 3'h2;
    localparam logic [2:0] MSEL_6K = 3'h3;
    localparam logic [2:0] MODE_STREAM = 3'h2;
    localparam logic [2:0] SRC_ADC   = 3'h0;
    localparam logic [2:0] SRC_DFT   = 3'h2;
    localparam logic [2:0] SRC_SINC2 = 3'h3;
    localparam logic [2:0] SRC_MEAN  = 3'h4;
    localparam logic [2:0] SRC_VAR   = 3'h5;
    localparam logic [4:0] TAG_DFT  = 5'h1F;
    localparam logic [6:0] TAG_MEAN = 7'h78;
    localparam logic [6:0] TAG_VAR  = 7'h74;
    localparam logic [1:0] FN_TRIG = 2'h1;
    localparam logic [1:0] FN_SYNC = 2'h2;
    localparam logic [2:0] EV_RISE = 3'h0;
    localparam logic [2:0] EV_FALL = 3'h1;
    localparam logic [2:0] EV_BOTH = 3'h2;
    localparam logic [2:0] EV_HIGH = 3'h3;
    localparam logic [2:0] EV_LOW  = 3'h4;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef struct packed {
        logic        valid;
        logic [17:0] data;
    } rsf_src_t;
    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
        logic [31:0] data;
    } rsf_seq_wr_t;
endpackage

/* File: rtl/rsf_result_fifo.sv */
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module rsf_result_fifo
    import rsf_pkg::*;
#(
    parameter int DEPTH = MEM_WORDS
)
(
    input  wire logic        clk_sys_i,
    input  wire logic        sys_rst_i,
    input  wire logic [15:0] s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [15:0] s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    input  wire rsf_src_t    adc_src_i,
    input  wire rsf_src_t    sinc2_src_i,
    input  wire rsf_src_t    dft_src_i,
    input  wire rsf_src_t    mean_src_i,
    input  wire rsf_src_t    var_src_i,
    input  wire logic [5:0]  conv_pos_sel_i,
    input  wire rsf_seq_wr_t seq_wr_i,
    input  wire logic        seq_busy_i,
    input  wire logic [7:0]  gpio_i,
    output logic [7:0]       gpio_o,
    output logic [7:0]       gpio_oe_o,
    output logic             seq_start_o,
    output logic [1:0]       seq_start_id_o,
    output logic             seq_ignored_o,
    output logic             seq_enable_o,
    output logic             seq_halt_o,
    output logic             buf_empty_o,
    output logic             buf_full_o,
    output logic             buf_overflow_o,
    output logic             buf_underflow_o,
    output logic             buf_thresh_o
);
    logic        aw_hold;
    logic        w_hold;
    logic [15:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        do_write;
    logic        host_ok;
    logic        ar_hs;
    logic        pop_req;
    logic [15:0] seq_ctrl;
    logic [15:0] buf_cfg;
    logic [15:0] mem_ctrl;
    logic [10:0] thr_lvl;
    logic [7:0]  sync_reg;
    logic [7:0]  pin_oe;
    logic [15:0] pin_fn;
    logic [23:0] pin_evt;
    logic        halt;
    logic        flush;
    logic [31:0] mem [DEPTH];
    logic [10:0] wr_ptr;
    logic [10:0] rd_ptr;
    logic [10:0] count;
    logic [10:0] cap;
    logic [10:0] next_wr;
    logic [10:0] next_rd;
    logic [10:0] next_count;
    logic        mem_we;
    logic        ovf;
    logic        unf;
    logic        push_v;
    logic [24:0] payload;
    logic [31:0] push_word;
    logic [1:0]  cur_seq_id;
    logic [7:0]  gpio_prev;
    logic [7:0]  req;
    logic [1:0]  first_id;
    logic        accept;
    logic        multi;

    assign halt = seq_ctrl[SEQ_HALT_BIT];
    assign do_write = aw_hold && w_hold && !s_axi_bvalid_o;
    assign ar_hs = s_axi_arvalid_i && s_axi_arready_o;
    assign pop_req = ar_hs && s_axi_araddr_i == A_POP;
    assign host_ok = do_write && !seq_wr_i.valid;
    assign flush = (seq_wr_i.valid && seq_wr_i.addr == A_MEM_CTRL) || (host_ok && aw_addr == A_MEM_CTRL);
    assign seq_enable_o = seq_ctrl[SEQ_EN_BIT];
    assign seq_halt_o = halt;
    assign gpio_oe_o = pin_oe;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        merge = old;
        for (int b = 0; b < 4; b++)
        begin
            if (s[b])
                merge[8*b +: 8] = d[8*b +: 8];
        end
    endfunction

    function automatic logic [31:0] upd(input logic [31:0] old, input logic [15:0] a);
        upd = old;
        if (seq_wr_i.valid && seq_wr_i.addr == a)
            upd = seq_wr_i.data;
        else if (host_ok && aw_addr == a)
            upd = merge(old, w_data, w_strb);
    endfunction

    function automatic logic writable(input logic [15:0] a);
        writable = a == A_SEQ_CTRL || a == A_BUF_CFG || a == A_SYNC || a == A_MEM_CTRL || a == A_THR
                   || a == A_PIN_OE || a == A_PIN_FN || a == A_PIN_EVT;
    endfunction

    function automatic logic [10:0] inc(input logic [10:0] p);
        inc = (p == cap - 11'h001) ? 11'h000 : p + 11'h001;
    endfunction

    function automatic logic [6:0] ecc7(input logic [24:0] d);
        ecc7 = 7'h00;
        for (int i = 0; i < 25; i++)
        begin
            for (int k = 0; k < 5; k++)
            begin
                if ((((i + 1) >> k) % 2) == 1)
                    ecc7[k] = ecc7[k] ^ d[i];
            end
            if (i < 12)
                ecc7[5] = ecc7[5] ^ d[i];
            ecc7[6] = ecc7[6] ^ d[i];
        end
    endfunction

    // Write address and data channels, response after both
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= 16'h0000;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o <= 1'b1;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid_i && s_axi_awready_o)
            begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr_i;
                s_axi_awready_o <= 1'b0;
            end
            if (s_axi_wvalid_i && s_axi_wready_o)
            begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata_i;
                w_strb <= s_axi_wstrb_i;
                s_axi_wready_o <= 1'b0;
            end
            if (do_write)
            begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= writable(aw_addr) ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid_o && s_axi_bready_i)
            begin
                s_axi_bvalid_o <= 1'b0;
                s_axi_awready_o <= 1'b1;
                s_axi_wready_o <= 1'b1;
            end
        end
    end

    // Read channel; a read of the pop port removes the head word unless halted
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h00000000;
            s_axi_rresp_o <= RESP_OKAY;
        end
        else if (ar_hs)
        begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b1;
            s_axi_rresp_o <= RESP_OKAY;
            unique case (s_axi_araddr_i)
                A_SEQ_CTRL: s_axi_rdata_o <= {16'h0000, seq_ctrl};
                A_BUF_CFG:  s_axi_rdata_o <= {16'h0000, buf_cfg};
                A_SYNC:     s_axi_rdata_o <= {24'h000000, sync_reg};
                A_POP:      s_axi_rdata_o <= (count == 11'h000) ? 32'h00000000 : mem[rd_ptr];
                A_MEM_CTRL: s_axi_rdata_o <= {16'h0000, mem_ctrl};
                A_THR:      s_axi_rdata_o <= {21'h000000, thr_lvl};
                A_OCC:      s_axi_rdata_o <= {5'h00, count, 16'h0000};
                A_FLAGS:    s_axi_rdata_o <= {27'h0000000, buf_thresh_o, buf_underflow_o,
                                              buf_overflow_o, buf_full_o, buf_empty_o};
                A_PIN_OE:   s_axi_rdata_o <= {24'h000000, pin_oe};
                A_PIN_FN:   s_axi_rdata_o <= {16'h0000, pin_fn};
                A_PIN_EVT:  s_axi_rdata_o <= {8'h00, pin_evt};
                default:
                begin
                    s_axi_rdata_o <= 32'h00000000;
                    s_axi_rresp_o <= RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid_o && s_axi_rready_i)
        begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_arready_o <= 1'b1;
        end
    end

    // Sequencer control: host writes always land here
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            seq_ctrl <= SEQ_CTRL_RST;
        else if (do_write && aw_addr == A_SEQ_CTRL)
            seq_ctrl <= 16'(merge({16'h0000, seq_ctrl}, w_data, w_strb));
        else if (seq_wr_i.valid && seq_wr_i.addr == A_SEQ_CTRL)
            seq_ctrl <= seq_wr_i.data[15:0];
    end

    // Configuration registers
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            buf_cfg <= BUF_CFG_RST;
            mem_ctrl <= MEM_CTRL_RST;
            thr_lvl <= 11'h000;
            sync_reg <= 8'h00;
            pin_oe <= 8'h00;
            pin_fn <= 16'h0000;
            pin_evt <= 24'h000000;
        end
        else
        begin
            buf_cfg <= 16'(upd({16'h0000, buf_cfg}, A_BUF_CFG));
            mem_ctrl <= 16'(upd({16'h0000, mem_ctrl}, A_MEM_CTRL));
            thr_lvl <= 11'(upd({21'h000000, thr_lvl}, A_THR));
            sync_reg <= 8'(upd({24'h000000, sync_reg}, A_SYNC));
            pin_oe <= 8'(upd({24'h000000, pin_oe}, A_PIN_OE));
            pin_fn <= 16'(upd({16'h0000, pin_fn}, A_PIN_FN));
            pin_evt <= 24'(upd({8'h00, pin_evt}, A_PIN_EVT));
        end
    end

    // Capacity from memory-size field
    always_comb
    begin
        unique case (mem_ctrl[MSEL_LSB +: 3])
            MSEL_4K: cap = CAP_4K;
            MSEL_6K: cap = CAP_6K;
            default: cap = CAP_2K;
        endcase
    end

    // Source select and tagged word
    always_comb
    begin
        push_v = 1'b0;
        payload = 25'h0000000;
        unique case (buf_cfg[SRC_LSB +: 3])
            SRC_ADC:
            begin
                push_v = adc_src_i.valid;
                payload = {cur_seq_id, 1'b0, conv_pos_sel_i, adc_src_i.data[15:0]};
            end
            SRC_SINC2:
            begin
                push_v = sinc2_src_i.valid;
                payload = {cur_seq_id, 1'b1, conv_pos_sel_i, sinc2_src_i.data[15:0]};
            end
            SRC_DFT:
            begin
                push_v = dft_src_i.valid;
                payload = {cur_seq_id, TAG_DFT, dft_src_i.data};
            end
            SRC_MEAN:
            begin
                push_v = mean_src_i.valid;
                payload = {cur_seq_id, TAG_MEAN, mean_src_i.data[15:0]};
            end
            SRC_VAR:
            begin
                push_v = var_src_i.valid;
                payload = {cur_seq_id, TAG_VAR, var_src_i.data[15:0]};
            end
            default:
            begin
                push_v = 1'b0;
                payload = 25'h0000000;
            end
        endcase
        push_v = push_v && buf_cfg[BUF_EN_BIT] && !halt;
        push_word = {ecc7(payload), payload};
    end

    // Pop first, then push with the full policy
    always_comb
    begin
        next_rd = rd_ptr;
        next_wr = wr_ptr;
        next_count = count;
        mem_we = 1'b0;
        ovf = 1'b0;
        unf = 1'b0;
        if (pop_req && !halt)
        begin
            if (count == 11'h000)
                unf = 1'b1;
            else
            begin
                next_rd = inc(rd_ptr);
                next_count = count - 11'h001;
            end
        end
        if (push_v)
        begin
            if (next_count != cap)
            begin
                mem_we = 1'b1;
                next_wr = inc(wr_ptr);
                next_count = next_count + 11'h001;
            end
            else
            begin
                ovf = 1'b1;
                if (mem_ctrl[MODE_LSB +: 3] == MODE_STREAM)
                begin
                    mem_we = 1'b1;
                    next_wr = inc(wr_ptr);
                    next_rd = inc(next_rd);
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (mem_we && !flush)
            mem[wr_ptr] <= push_word;
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            wr_ptr <= 11'h000;
            rd_ptr <= 11'h000;
            count <= 11'h000;
        end
        else if (flush)
        begin
            wr_ptr <= 11'h000;
            rd_ptr <= 11'h000;
            count <= 11'h000;
        end
        else
        begin
            wr_ptr <= next_wr;
            rd_ptr <= next_rd;
            count <= next_count;
        end
    end

    // Status flags
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            buf_empty_o <= 1'b1;
            buf_full_o <= 1'b0;
            buf_overflow_o <= 1'b0;
            buf_underflow_o <= 1'b0;
            buf_thresh_o <= 1'b1;
        end
        else
        begin
            buf_empty_o <= flush || next_count == 11'h000;
            buf_full_o <= !flush && next_count == cap;
            buf_overflow_o <= ovf && !flush;
            buf_underflow_o <= unf;
            buf_thresh_o <= (flush ? 11'h000 : next_count) >= thr_lvl;
        end
    end

    // Pin events and sequence launch
    always_comb
    begin
        req = 8'h00;
        first_id = 2'h0;
        for (int i = 7; i >= 0; i--)
        begin
            if (!pin_oe[i] && pin_fn[2*i +: 2] == FN_TRIG)
            begin
                unique case (pin_evt[3*i +: 3])
                    EV_RISE: req[i] = gpio_i[i] && !gpio_prev[i];
                    EV_FALL: req[i] = !gpio_i[i] && gpio_prev[i];
                    EV_BOTH: req[i] = gpio_i[i] != gpio_prev[i];
                    EV_HIGH: req[i] = gpio_i[i];
                    EV_LOW:  req[i] = !gpio_i[i];
                    default: req[i] = 1'b0;
                endcase
            end
            if (req[i])
                first_id = 2'(i);
        end
        multi = (req & (req - 8'h01)) != 8'h00;
        accept = req != 8'h00 && seq_enable_o && !halt && !seq_busy_i && !seq_start_o;
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            gpio_prev <= 8'h00;
            seq_start_o <= 1'b0;
            seq_start_id_o <= 2'h0;
            seq_ignored_o <= 1'b0;
            cur_seq_id <= 2'h0;
        end
        else
        begin
            gpio_prev <= gpio_i;
            seq_start_o <= accept;
            seq_ignored_o <= seq_enable_o && !halt && req != 8'h00 && (!accept || multi);
            if (accept)
            begin
                seq_start_id_o <= first_id;
                cur_seq_id <= first_id;
            end
        end
    end

    // Sync pins toggled by sequencer writes
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            gpio_o <= 8'h00;
        else if (seq_wr_i.valid && seq_wr_i.addr == A_SYNC)
        begin
            for (int i = 0; i < 8; i++)
            begin
                if (pin_oe[i] && pin_fn[2*i +: 2] == FN_SYNC && seq_wr_i.data[i])
                    gpio_o[i] <= !gpio_o[i];
            end
        end
    end

    a_unf_pulse: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        buf_underflow_o |=> !buf_underflow_o) else $error("underflow held");
    a_empty_pop_zero: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (pop_req && !halt && count == 11'h000) |=> s_axi_rvalid_o && s_axi_rdata_o == 32'h00000000
        && buf_underflow_o) else $error("empty pop wrong");
    a_queue_keep: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (push_v && count == cap && !pop_req && !flush && mem_ctrl[MODE_LSB +: 3] != MODE_STREAM)
        |=> count == $past(count) && wr_ptr == $past(wr_ptr) && buf_overflow_o) else $error("queue overwrite");
    a_stream_drop: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (push_v && count == cap && !pop_req && !flush && mem_ctrl[MODE_LSB +: 3] == MODE_STREAM)
        |=> count == $past(count) && rd_ptr != $past(rd_ptr)) else $error("stream no drop");
    a_disabled_idle: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (!buf_cfg[BUF_EN_BIT] && !pop_req && !flush) |=> count == $past(count)) else $error("push while off");
    a_cap_bound: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        count <= cap) else $error("count over capacity");
    a_thr_flag: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        ($stable(thr_lvl) && !$past(flush)) |-> buf_thresh_o == (count >= thr_lvl)) else $error("threshold wrong");
    a_busy_ignore: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (req != 8'h00 && seq_busy_i && seq_enable_o && !halt) |=> seq_ignored_o && !seq_start_o)
        else $error("busy request not ignored");
    a_host_drop: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (do_write && aw_addr == A_THR && seq_wr_i.valid && seq_wr_i.addr != A_THR)
        |=> $stable(thr_lvl)) else $error("host write not dropped");
    a_halt_freeze: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (halt && !flush) |=> count == $past(count) && !seq_start_o) else $error("halt not frozen");
    a_sync_toggle: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (seq_wr_i.valid && seq_wr_i.addr == A_SYNC && seq_wr_i.data[0] && pin_oe[0] && pin_fn[1:0] == FN_SYNC)
        |=> gpio_o[0] != $past(gpio_o[0])) else $error("sync pin not toggled");
endmodule

/* File: bench/rsf_host_model.sv */
`timescale 1ns/1ps
module rsf_host_model
(
    input  wire logic   clk_sys_i,
    input  wire logic   s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o,
    output logic [15:0] s_axi_awaddr_i, s_axi_araddr_i,
    output logic [31:0] s_axi_wdata_i,
    output logic [3:0]  s_axi_wstrb_i,
    output logic        s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i,
    output logic        host_timeout_o
);
    initial {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, s_axi_wstrb_i, s_axi_awvalid_i, s_axi_wvalid_i,
             s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i, host_timeout_o} = '0;
    // Full-strobe write to any register address; raises the timeout flag after 100 cycles without a response
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        bit done;
        done = 0;
        @(posedge clk_sys_i);
        {s_axi_awaddr_i, s_axi_wdata_i, s_axi_wstrb_i} <= {a, d, 4'hF};
        {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
        for (int k = 0; k < 100 && !done; k++)
        begin
            @(posedge clk_sys_i);
            if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
            done = s_axi_bvalid_o;
        end
        s_axi_bready_i <= 1'b0;
        if (!done) host_timeout_o <= 1'b1;
    endtask
    task automatic rd(input logic [15:0] a);
        bit done;
        done = 0;
        @(posedge clk_sys_i);
        {s_axi_araddr_i, s_axi_arvalid_i, s_axi_rready_i} <= {a, 2'h3};
        for (int k = 0; k < 100 && !done; k++)
        begin
            @(posedge clk_sys_i);
            if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
            done = s_axi_rvalid_o;
        end
        s_axi_rready_i <= 1'b0;
        if (!done) host_timeout_o <= 1'b1;
    endtask
endmodule

/* File: bench/rsf_result_fifo_tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module rsf_result_fifo_tb;
    import rsf_pkg::*;
    logic clk_sys_i = 0, sys_rst_i = 1, seq_busy_i = 0, host_timeout_o;
    logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i;
    logic s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
    logic [15:0] s_axi_awaddr_i, s_axi_araddr_i;
    logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
    logic [3:0]  s_axi_wstrb_i;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, seq_start_id_o;
    rsf_src_t    adc_src_i = '0, sinc2_src_i = '0, dft_src_i = '0, mean_src_i = '0, var_src_i = '0;
    rsf_seq_wr_t seq_wr_i = '0;
    logic [5:0]  conv_pos_sel_i = '0;
    logic [7:0]  gpio_i = '0, gpio_o, gpio_oe_o;
    logic seq_start_o, seq_ignored_o, seq_enable_o, seq_halt_o;
    logic buf_empty_o, buf_full_o, buf_overflow_o, buf_underflow_o, buf_thresh_o;
    int n_errors = 0, total_checks = 0, n_ovf = 0, n_unf = 0;
    logic [63:0] exp_q[$];
    logic [63:0] e;
    logic [17:0] dv [5];
    logic [22:0] x;
    logic [15:0] ra [5] = '{A_SEQ_CTRL, A_BUF_CFG, A_MEM_CTRL, A_OCC, 16'h2100};
    logic [31:0] rv [5] = '{32'h2, 32'h1010, 32'h410, 32'h0, 32'h0};
    logic [2:0]  sc [5] = '{SRC_ADC, SRC_SINC2, SRC_DFT, SRC_MEAN, SRC_VAR};
    logic [31:0] mc [4] = '{32'h0, 32'h400, 32'h80, 32'hC0};
    int          cap [4] = '{512, 512, 1024, 1536};
    rsf_result_fifo dut (.*);
    rsf_host_model host (.*);
    always #10 clk_sys_i = ~clk_sys_i;
    always @(negedge clk_sys_i)
    begin
        n_ovf += buf_overflow_o;
        n_unf += buf_underflow_o;
    end
    always @(posedge clk_sys_i)
        if (s_axi_rvalid_o === 1'b1 && s_axi_rready_i === 1'b1)
        begin
            e = exp_q.pop_front();
            `CHK(s_axi_rdata_o & e[63:32], e[31:0])
        end
    always @(posedge host_timeout_o)
    begin
        n_errors++;
        end_sim();
    end
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic rd_exp(input logic [15:0] a, input logic [31:0] v, input logic [31:0] m);
        exp_q.push_back({m, v});
        host.rd(a);
    endtask
    task automatic push_adc(input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk_sys_i);
            adc_src_i <= {1'b1, 18'(i)};
        end
        @(posedge clk_sys_i);
        adc_src_i <= '0;
    endtask
    initial
    begin
        void'($urandom(32'hC57084CD));
        conv_pos_sel_i <= 6'($urandom);
        repeat (6) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        for (int i = 0; i < 5; i++) rd_exp(ra[i], rv[i], 32'hFFFFFFFF);
        $display("test reset values done");
        for (int s = 0; s < 5; s++)
        begin
            host.wr(A_BUF_CFG, (32'h1 << BUF_EN_BIT) | (32'(sc[s]) << SRC_LSB));
            for (int k = 0; k < 5; k++) dv[k] = 18'($urandom);
            @(posedge clk_sys_i);
            {adc_src_i, sinc2_src_i, dft_src_i} <= {1'b1, dv[0], 1'b1, dv[1], 1'b1, dv[2]};
            {mean_src_i, var_src_i} <= {1'b1, dv[3], 1'b1, dv[4]};
            @(posedge clk_sys_i);
            {adc_src_i, sinc2_src_i, dft_src_i, mean_src_i, var_src_i} <= '0;
            x = (s == 0) ? {1'b0, conv_pos_sel_i, dv[0][15:0]} : (s == 1) ? {1'b1, conv_pos_sel_i, dv[1][15:0]} :
                (s == 2) ? {TAG_DFT, dv[2]} : (s == 3) ? {TAG_MEAN, dv[3][15:0]} : {TAG_VAR, dv[4][15:0]};
            rd_exp(A_POP, {9'h0, x}, 32'h01FFFFFF);
        end
        $display("test sources done");
        n_unf = 0;
        rd_exp(A_POP, 32'h0, 32'hFFFFFFFF);
        repeat (2) @(posedge clk_sys_i);
        `CHK(n_unf, 1)
        host.wr(A_THR, 32'h2);
        host.wr(A_BUF_CFG, 32'h1 << BUF_EN_BIT);
        push_adc(1);
        @(posedge clk_sys_i);
        `CHK(buf_thresh_o, 1'b0)
        push_adc(1);
        @(posedge clk_sys_i);
        `CHK(buf_thresh_o, 1'b1)
        rd_exp(A_OCC, 32'h2 << OCC_LSB, 32'hFFFFFFFF);
        $display("test threshold done");
        for (int m = 0; m < 4; m++)
        begin
            host.wr(A_MEM_CTRL, mc[m]);
            n_ovf = 0;
            push_adc(cap[m] + 1);
            repeat (2) @(posedge clk_sys_i);
            `CHK(buf_full_o, 1'b1)
            `CHK(n_ovf, 1)
            rd_exp(A_OCC, 32'(cap[m]) << OCC_LSB, 32'hFFFFFFFF);
            rd_exp(A_POP, (m == 1) ? 32'h1 : 32'h0, 32'hFFFF);
        end
        $display("test full policy done");
        host.wr(A_MEM_CTRL, 32'h0);
        host.wr(A_PIN_OE, 32'h1);
        host.wr(A_PIN_FN, 32'h402);
        host.wr(A_SEQ_CTRL, 32'h1);
        @(posedge clk_sys_i) gpio_i <= 8'h20;
        repeat (2) @(negedge clk_sys_i);
        `CHK({seq_start_o, seq_start_id_o, seq_ignored_o, seq_enable_o}, 5'b10101)
        @(posedge clk_sys_i) {seq_busy_i, gpio_i} <= {1'b1, 8'h00};
        @(posedge clk_sys_i) gpio_i <= 8'h20;
        repeat (2) @(negedge clk_sys_i);
        `CHK({seq_start_o, seq_ignored_o}, 2'b01)
        push_adc(1);
        rd_exp(A_POP, 32'h00800000, 32'h01800000);
        fork
            host.wr(A_THR, 32'h5);
            begin
                repeat (2) @(posedge clk_sys_i);
                seq_wr_i <= {1'b1, A_SYNC, 32'h1};
                @(posedge clk_sys_i);
                seq_wr_i <= '0;
            end
        join
        @(negedge clk_sys_i);
        `CHK({gpio_oe_o, gpio_o}, 16'h0101)
        rd_exp(A_THR, 32'h2, 32'hFFFFFFFF);
        host.wr(A_SEQ_CTRL, 32'h11);
        push_adc(1);
        @(negedge clk_sys_i);
        `CHK({seq_halt_o, buf_empty_o}, 2'b11)
        $display("test launch done");
        repeat (3) @(posedge clk_sys_i);
        end_sim();
    end
endmodule
